/* logic/rles_edge_setup.sv */
// Edge setup: parameter store, edge stepping and per-primitive qualification
// Notes on behaviour
// - Dominant edge X starts from a signed 16.16 start register.
// - Each step adds the dominant X step, or a point table word for point-table antialiased trapezoids, to the dominant edge X.
// - Subordinate edge X starts from a 16.16 start register.
// - Each step adds the subordinate X step to the subordinate edge X.
// - Y starts from the 16.16 initial Y register.
// - Each step adds the Y step to Y, its sign giving the scan direction.
// - The 16-bit count means pixels, scanlines, sub-scanlines or diameter by primitive.
// - A scanline is filled only when lower <= Y < upper; others are suppressed.
// - Four antialias point words are held, the write address selecting the word.
// - A 32-bit stipple mask word masks fragments when bitmask stippling is on.
// - Render command bits qualify stipple, texture, haze, coverage, subpixel state per primitive.
// - Clearing render bits skips unit operations without reloading unit configs.
// - Only scanlines assigned by the ownership register are rasterized.
// - Area stippling needs both the render bit and the unit's own enable.
// - Continue counts drive that continuation only and never touch the count register.
`timescale 1ns/100ps
`default_nettype none
module rles_edge_setup
  import rles_pkg::*;
(
  input wire logic ref_clk, // 200 MHz core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic area_unit_on, // Stipple unit area enable
  input wire logic line_unit_on, // Stipple unit line enable
  input wire logic haze_unit_on, // Haze unit enable
  input wire logic tex_unit_on, // Texture unit enable
  input wire logic mask_unit_on, // Bitmask stipple enable
  input wire logic frag_ready, // Pipeline takes a step
  output logic frag_valid, // Step data valid
  output logic frag_keep, // Scanline clipped in and owned
  output logic frag_masked, // Bitmask stipple drops fragment
  output logic [31:0] frag_x_dom, // Dominant edge X, 16.16
  output logic [31:0] frag_x_sub, // Subordinate edge X, 16.16
  output logic [31:0] frag_y, // Current Y, 16.16
  output logic area_pattern_on, // Area stipple active
  output logic line_pattern_on, // Line stipple active
  output logic line_pattern_restart, // One-cycle restart pulse
  output logic texturing_on, // Texture active
  output logic haze_on, // Haze active
  output logic coverage_on, // Coverage active
  output logic frac_fix_on, // Subpixel correction active
  output logic busy // Primitive in progress
);
  import rles_pkg::*;

  // Integer part of a 16.16 value
  function automatic logic signed [15:0] fx_int(input logic [31:0] v);
    fx_int = $signed(v[31:16]);
  endfunction

  logic rst_s1, rst_s2;
  logic [31:0] dominant_x_start, dominant_x_step;
  logic [31:0] subordinate_x_start, subordinate_x_step;
  logic [31:0] y_initial, y_step, stipple_mask_word;
  logic [31:0] y_clip_bounds, owner_word, render_word;
  logic [15:0] step_count, remain;
  logic [31:0] aa_point_word [4];
  logic [31:0] x_dom, x_sub, y_cur, dom_inc;
  rles_state_type state;
  logic wr_render, wr_cont, step, fill_in, owned;
  logic signed [15:0] y_int, y_min, y_max;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  assign wr_render = reg_wr && reg_addr == OFS_RENDER;
  assign wr_cont = reg_wr && reg_addr == OFS_CONT;
  assign step = state == RLES_RUN && frag_ready;

  // Parameter store writes
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      dominant_x_start <= RST_WORD;
      dominant_x_step <= RST_WORD;
      subordinate_x_start <= RST_WORD;
      subordinate_x_step <= RST_WORD;
      y_initial <= RST_WORD;
      y_step <= RST_WORD;
      step_count <= RST_COUNT;
      stipple_mask_word <= RST_WORD;
      y_clip_bounds <= RST_YCLIP;
      owner_word <= RST_OWNER;
      render_word <= RST_WORD;
      for (int i = 0; i < 4; i++) begin
        aa_point_word[i] <= RST_WORD;
      end
    end else if (reg_wr) begin
      if (reg_addr == OFS_DOM_START) begin
        dominant_x_start <= reg_wdata;
      end else if (reg_addr == OFS_DOM_STEP) begin
        dominant_x_step <= reg_wdata;
      end else if (reg_addr == OFS_SUB_START) begin
        subordinate_x_start <= reg_wdata;
      end else if (reg_addr == OFS_SUB_STEP) begin
        subordinate_x_step <= reg_wdata;
      end else if (reg_addr == OFS_Y_INIT) begin
        y_initial <= reg_wdata;
      end else if (reg_addr == OFS_Y_STEP) begin
        y_step <= reg_wdata;
      end else if (reg_addr == OFS_COUNT) begin
        step_count <= reg_wdata[15:0];
      end else if (reg_addr == OFS_MASK) begin
        stipple_mask_word <= reg_wdata;
      end else if (reg_addr >= OFS_PT0 && reg_addr <= OFS_PT3) begin
        aa_point_word[reg_addr[3:2]] <= reg_wdata;
      end else if (reg_addr == OFS_YCLIP) begin
        y_clip_bounds <= reg_wdata;
      end else if (reg_addr == OFS_OWNER) begin
        owner_word <= reg_wdata;
      end else if (reg_addr == OFS_RENDER) begin
        render_word <= reg_wdata;
      end
    end
  end

  // Read data, one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      reg_rdata <= RST_WORD;
    end else if (reg_rd) begin
      if (reg_addr == OFS_DOM_START) begin
        reg_rdata <= dominant_x_start;
      end else if (reg_addr == OFS_DOM_STEP) begin
        reg_rdata <= dominant_x_step;
      end else if (reg_addr == OFS_SUB_START) begin
        reg_rdata <= subordinate_x_start;
      end else if (reg_addr == OFS_SUB_STEP) begin
        reg_rdata <= subordinate_x_step;
      end else if (reg_addr == OFS_Y_INIT) begin
        reg_rdata <= y_initial;
      end else if (reg_addr == OFS_Y_STEP) begin
        reg_rdata <= y_step;
      end else if (reg_addr == OFS_COUNT) begin
        reg_rdata <= {16'h0000, step_count};
      end else if (reg_addr == OFS_MASK) begin
        reg_rdata <= stipple_mask_word;
      end else if (reg_addr >= OFS_PT0 && reg_addr <= OFS_PT3) begin
        reg_rdata <= aa_point_word[reg_addr[3:2]];
      end else if (reg_addr == OFS_YCLIP) begin
        reg_rdata <= y_clip_bounds;
      end else if (reg_addr == OFS_OWNER) begin
        reg_rdata <= owner_word;
      end else if (reg_addr == OFS_RENDER) begin
        reg_rdata <= render_word;
      end else if (reg_addr == OFS_STATUS) begin
        reg_rdata <= {15'h0000, busy, remain};
      end else begin
        reg_rdata <= RST_WORD;
      end
    end else begin
      reg_rdata <= RST_WORD;
    end
  end

  // Antialiased trapezoids may take dominant dx from the point table
  always_comb begin
    dom_inc = dominant_x_step;
    if (render_word[RB_AA] && render_word[RB_USE_PT]
        && render_word[RB_PRIM_LO +: 2] == PRIM_TRAP) begin
      dom_inc = aa_point_word[remain[1:0]];
    end
  end

  // Sequencer: render loads all edges, continue reuses them
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= RLES_IDLE;
      remain <= RST_COUNT;
    end else begin
      case (state)
        RLES_IDLE: begin
          if (wr_render && step_count != 16'h0000) begin
            remain <= step_count;
            state <= RLES_RUN;
          end else if (wr_cont && reg_wdata[15:0] != 16'h0000) begin
            remain <= reg_wdata[15:0];
            state <= RLES_RUN;
          end
        end
        RLES_RUN: begin
          if (step) begin
            remain <= remain - 16'h0001;
            if (remain == 16'h0001) begin
              state <= RLES_IDLE;
            end
          end
        end
        default: state <= RLES_IDLE;
      endcase
    end
  end

  // Edge DDAs; start writes arriving mid-primitive only affect the next one, step writes apply at once
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      x_dom <= RST_WORD;
      x_sub <= RST_WORD;
      y_cur <= RST_WORD;
    end else if (state == RLES_IDLE && wr_render) begin
      x_dom <= dominant_x_start;
      x_sub <= subordinate_x_start;
      y_cur <= y_initial;
    end else if (step) begin
      x_dom <= x_dom + dom_inc;
      x_sub <= x_sub + subordinate_x_step;
      y_cur <= y_cur + y_step;
    end
  end

  // Clip and ownership tests on the integer scanline
  assign y_int = fx_int(y_cur);
  assign y_max = $signed(y_clip_bounds[YC_MAX_LO +: 16]);
  assign y_min = $signed(y_clip_bounds[YC_MIN_LO +: 16]);
  assign fill_in = y_int >= y_min && y_int < y_max;
  // Zero mask with zero match owns every line, so single-chip use needs no setup
  assign owned = (y_cur[31:16] & owner_word[OWN_MASK_LO +: 16])
                 == owner_word[15:0];
  assign frag_valid = state == RLES_RUN;
  assign frag_keep = frag_valid && fill_in && owned;
  assign frag_masked = frag_valid && mask_unit_on
                       && !stipple_mask_word[x_dom[20:16]];
  assign frag_x_dom = x_dom;
  assign frag_x_sub = x_sub;
  assign frag_y = y_cur;
  assign busy = state == RLES_RUN;

  // Unit gating: unit configs stay on, render bits switch per primitive
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      area_pattern_on <= 1'b0;
      line_pattern_on <= 1'b0;
      texturing_on <= 1'b0;
      haze_on <= 1'b0;
      coverage_on <= 1'b0;
      frac_fix_on <= 1'b0;
    end else begin
      area_pattern_on <= render_word[RB_AREA] && area_unit_on;
      line_pattern_on <= render_word[RB_LINE] && line_unit_on;
      texturing_on <= render_word[RB_TEX] && tex_unit_on;
      haze_on <= render_word[RB_HAZE] && haze_unit_on;
      coverage_on <= render_word[RB_COV];
      frac_fix_on <= render_word[RB_SUBPIX];
    end
  end

  // Restart pulse, qualified by the line enables, on a render write while idle with the restart bit set, even with a zero count
  always_ff @(posedge ref_clk or negedge rst_s2) begin
    if (!rst_s2) begin
      line_pattern_restart <= 1'b0;
    end else begin
      line_pattern_restart <= state == RLES_IDLE && wr_render
                              && reg_wdata[RB_LRST] && reg_wdata[RB_LINE]
                              && line_unit_on;
    end
  end

  // Checks
  sequence s_render_go;
    state == RLES_IDLE && wr_render && step_count != 16'h0000;
  endsequence
  sequence s_last_step;
    step && remain == 16'h0001;
  endsequence
  // Point table drives dominant dx only for antialiased trapezoids
  sequence s_pt_step;
    step && render_word[RB_AA] && render_word[RB_USE_PT]
      && render_word[RB_PRIM_LO +: 2] == PRIM_TRAP;
  endsequence
  sequence s_restart_req;
    state == RLES_IDLE && wr_render && reg_wdata[RB_LRST] && reg_wdata[RB_LINE]
      && line_unit_on;
  endsequence

  chk_count_load: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    s_render_go |=> busy && remain == $past(step_count))
    else $error("count not loaded at render");
  chk_end_zero: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    s_last_step |=> !busy && remain == 16'h0000)
    else $error("primitive did not end at zero");
  chk_dom_add: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    step |=> x_dom == $past(x_dom) + $past(dom_inc))
    else $error("dominant X not stepped");
  chk_sub_add: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    step |=> x_sub == $past(x_sub) + $past(subordinate_x_step))
    else $error("subordinate X not stepped");
  chk_y_add: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    step |=> y_cur == $past(y_cur) + $past(y_step))
    else $error("Y not stepped");
  chk_start_load: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    s_render_go |=> x_dom == $past(dominant_x_start) && y_cur == $past(y_initial)
      && x_sub == $past(subordinate_x_start))
    else $error("edges not loaded from start values");
  chk_clip_keep: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    frag_keep |-> y_int >= $signed(y_clip_bounds[15:0])
      && y_int < $signed(y_clip_bounds[31:16]))
    else $error("fragment kept outside Y bounds");
  chk_cont_count: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    state == RLES_IDLE && wr_cont && reg_wdata[15:0] != 16'h0000
      |=> busy && remain == $past(reg_wdata[15:0]) && $stable(step_count))
    else $error("continue count misused");
  chk_area_gate: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    ##1 area_pattern_on == ($past(render_word[0]) && $past(area_unit_on)))
    else $error("area stipple gate wrong");
  chk_read_count: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    reg_rd && reg_addr == OFS_COUNT |=> reg_rdata == {16'h0000, $past(step_count)})
    else $error("count readback wrong");
  chk_point_inc: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    s_pt_step |=> x_dom == $past(x_dom) + $past(aa_point_word[remain[1:0]]))
    else $error("point table increment not used");
  chk_zero_start: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    state == RLES_IDLE && wr_render && step_count == 16'h0000 |=> !busy)
    else $error("zero count started a primitive");
  chk_haze_gate: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    ##1 haze_on == ($past(render_word[RB_HAZE]) && $past(haze_unit_on)))
    else $error("haze gate wrong");
  chk_line_gate: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    ##1 line_pattern_on == ($past(render_word[RB_LINE]) && $past(line_unit_on)))
    else $error("line stipple gate wrong");
  chk_tex_gate: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    ##1 texturing_on == ($past(render_word[RB_TEX]) && $past(tex_unit_on)))
    else $error("texture gate wrong");
  chk_restart_set: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    s_restart_req |=> line_pattern_restart)
    else $error("line stipple restart missing");
  chk_restart_src: assert property (@(posedge ref_clk) disable iff (!rst_s2)
    line_pattern_restart |-> $past(wr_render) && $past(line_unit_on))
    else $error("line stipple restart without render");
endmodule
`default_nettype wire

/* logic/rles_pkg.sv */
// Package: register map, field positions and reset values for the edge setup block
package rles_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DOM_START = 8'h00;
  localparam logic [7:0] OFS_DOM_STEP = 8'h04;
  localparam logic [7:0] OFS_SUB_START = 8'h08;
  localparam logic [7:0] OFS_SUB_STEP = 8'h0c;
  localparam logic [7:0] OFS_Y_INIT = 8'h10;
  localparam logic [7:0] OFS_Y_STEP = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1c;
  localparam logic [7:0] OFS_PT0 = 8'h20;
  localparam logic [7:0] OFS_PT3 = 8'h2c;
  localparam logic [7:0] OFS_YCLIP = 8'h30;
  localparam logic [7:0] OFS_OWNER = 8'h34;
  localparam logic [7:0] OFS_RENDER = 8'h38;
  localparam logic [7:0] OFS_CONT = 8'h3c;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  // Render command fields
  localparam int RB_AREA = 0;
  localparam int RB_LINE = 1;
  localparam int RB_LRST = 2;
  localparam int RB_PRIM_LO = 6;
  localparam int RB_AA = 8;
  localparam int RB_USE_PT = 10;
  localparam int RB_TEX = 12;
  localparam int RB_HAZE = 13;
  localparam int RB_COV = 14;
  localparam int RB_SUBPIX = 15;
  // Y clip bound halves
  localparam int YC_MAX_LO = 16;
  localparam int YC_MIN_LO = 0;
  // Ownership: mask in upper half, match value in lower half
  localparam int OWN_MASK_LO = 16;
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [31:0] RST_YCLIP = 32'h7fff_8000;
  localparam logic [31:0] RST_OWNER = 32'h0000_0000;
  // Primitive kinds
  localparam logic [1:0] PRIM_LINE = 2'h0;
  localparam logic [1:0] PRIM_TRAP = 2'h1;
  localparam logic [1:0] PRIM_POINT = 2'h2;
  typedef enum logic {RLES_IDLE, RLES_RUN} rles_state_type;
endpackage

/* tb/rasterizer_edge_setup_tb.sv */
// Self-checking bench for the edge setup block
`timescale 1ns/100ps
`default_nettype none
module rasterizer_edge_setup_tb;
  import rles_pkg::*;
  logic ref_clk, rst_n, reg_wr, reg_rd, slow;
  logic area_unit_on, line_unit_on, haze_unit_on, tex_unit_on, mask_unit_on;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, frag_x_dom, frag_x_sub, frag_y, mask;
  logic frag_ready, frag_valid, frag_keep, frag_masked, busy;
  logic area_pattern_on, line_pattern_on, line_pattern_restart, texturing_on, haze_on, coverage_on, frac_fix_on;
  logic [15:0] taken, omask, omatch;
  logic signed [15:0] ymin, ymax;
  logic [31:0] pt [4];
  int num_errors = 0;
  int check_count = 0;

  rles_edge_setup i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .area_unit_on(area_unit_on),
    .line_unit_on(line_unit_on), .haze_unit_on(haze_unit_on), .tex_unit_on(tex_unit_on),
    .mask_unit_on(mask_unit_on), .frag_ready(frag_ready), .frag_valid(frag_valid), .frag_keep(frag_keep),
    .frag_masked(frag_masked), .frag_x_dom(frag_x_dom), .frag_x_sub(frag_x_sub), .frag_y(frag_y),
    .area_pattern_on(area_pattern_on), .line_pattern_on(line_pattern_on),
    .line_pattern_restart(line_pattern_restart), .texturing_on(texturing_on), .haze_on(haze_on),
    .coverage_on(coverage_on), .frac_fix_on(frac_fix_on), .busy(busy));
  rles_pipe_model i_pipe (.ref_clk(ref_clk), .rst_n(rst_n), .slow(slow), .frag_valid(frag_valid),
    .frag_ready(frag_ready), .taken(taken));

  // 200 MHz core clock
  always #2.5 ref_clk = ~ref_clk;

  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bus cycles: strobes last one cycle, read data stands in the next cycle only
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Load edges, start a line or antialiased trapezoid and follow every accepted step at the falling edge
  task automatic run_check(input logic [15:0] n, input logic [31:0] xd, dxd, xs, dxs, y, dy, input logic use_pt);
    logic [15:0] i;
    logic [15:0] r;
    logic [31:0] w;
    logic kp;
    i = 16'h0000;
    w = 32'h0000_0000;
    w[RB_AA] = use_pt;
    w[RB_USE_PT] = use_pt;
    w[RB_PRIM_LO +: 2] = use_pt ? PRIM_TRAP : PRIM_LINE;
    wr(OFS_DOM_START, xd);
    wr(OFS_DOM_STEP, dxd);
    wr(OFS_SUB_START, xs);
    wr(OFS_SUB_STEP, dxs);
    wr(OFS_Y_INIT, y);
    wr(OFS_Y_STEP, dy);
    wr(OFS_COUNT, {16'h0000, n});
    wr(OFS_RENDER, w);
    repeat (100) begin
      @(negedge ref_clk);
      if (frag_valid === 1'b1 && frag_ready === 1'b1) begin
        kp = ($signed(y[31:16]) >= ymin) && ($signed(y[31:16]) < ymax) && ((y[31:16] & omask) == omatch);
        cmp("x_dom", xd, frag_x_dom);
        cmp("x_sub", xs, frag_x_sub);
        cmp("y", y, frag_y);
        cmp("keep", {31'h0, kp}, {31'h0, frag_keep});
        cmp("masked", {31'h0, mask_unit_on & ~mask[xd[20:16]]}, {31'h0, frag_masked});
        r = n - i;
        xd = xd + (use_pt ? pt[r[1:0]] : dxd);
        xs = xs + dxs;
        y = y + dy;
        i = i + 16'h0001;
      end
    end
    cmp("steps", {16'h0, n}, {16'h0, i});
    cmp("busy", 32'h0, {31'h0, busy});
  endtask

  // Y clip reset value, readback of every word up to the ownership register, unmapped and read-only places
  task automatic test_regs();
    logic [31:0] d;
    logic [31:0] v;
    rd(OFS_YCLIP, d);
    cmp("yclip_rst", RST_YCLIP, d);
    for (int a = 0; a < 14; a++) wr(8'(a * 4), 32'h8765_4321 + 32'(a));
    for (int a = 0; a < 14; a++) begin
      v = 32'h8765_4321 + 32'(a);
      rd(8'(a * 4), d);
      cmp("reg", (a == 6) ? {16'h0, v[15:0]} : v, d);
    end
    rd(8'h44, d);
    cmp("unmapped", 32'h0, d);
    wr(OFS_STATUS, 32'hffff_ffff);
    rd(OFS_STATUS, d);
    cmp("status", 32'h0, d);
  endtask

  // Stalled line upward, then prompt line downward with negative clip and ownership
  task automatic test_line();
    mask = 32'h0000_0005;
    ymin = 16'sh0000;
    ymax = 16'sh0002;
    omask = 16'h0000;
    omatch = 16'h0000;
    wr(OFS_MASK, mask);
    wr(OFS_YCLIP, 32'h0002_0000);
    wr(OFS_OWNER, 32'h0000_0000);
    slow <= 1'b1;
    run_check(16'h0004, 32'h0001_0000, 32'h0000_8000, 32'h0002_0000, 32'hffff_0000, 32'h0, 32'h0001_0000,
      1'b0);
    ymin = -16'sh0001;
    ymax = 16'sh0001;
    omask = 16'h0001;
    omatch = 16'h0001;
    wr(OFS_YCLIP, 32'h0001_ffff);
    wr(OFS_OWNER, 32'h0001_0001);
    slow <= 1'b0;
    mask_unit_on <= 1'b0;
    run_check(16'h0003, 32'h0010_0000, 32'hffff_0000, 32'h0, 32'h0000_8000, 32'h0, 32'hffff_0000,
      1'b0);
    // Antialiased trapezoid: dominant dx comes from the point table, not the step register
    for (int j = 0; j < 4; j++) begin
      pt[j] = {16'(j + 1), 16'h0000};
      wr(8'(OFS_PT0 + j * 4), pt[j]);
    end
    run_check(16'h0004, 32'h0, 32'h0008_0000, 32'h0, 32'h0, 32'h0, 32'hffff_0000, 1'b1);
  endtask

  // Render bits against unit enables, with no primitive started
  task automatic test_gates();
    logic [31:0] w;
    logic u;
    wr(OFS_COUNT, 32'h0);
    for (int k = 0; k < 4; k++) begin
      u = k[0];
      w = k[1] ? 32'h0000_f007 : 32'h0;
      @(posedge ref_clk);
      area_unit_on <= u;
      line_unit_on <= u;
      haze_unit_on <= u;
      tex_unit_on <= u;
      wr(OFS_RENDER, w);
      #1;
      cmp("restart", {31'h0, u & w[2] & w[1]}, {31'h0, line_pattern_restart});
      @(posedge ref_clk);
      #1;
      cmp("gates", {25'h0, 1'b0, u & w[0], u & w[1], u & w[12], u & w[13], w[14], w[15]},
        {25'h0, line_pattern_restart, area_pattern_on, line_pattern_on, texturing_on, haze_on, coverage_on, frac_fix_on});
    end
  endtask

  // A continuation runs its own count and leaves the count register alone
  task automatic test_continue();
    logic [15:0] t0;
    logic [31:0] d;
    t0 = taken;
    wr(OFS_CONT, 32'h0000_0005);
    rd(OFS_STATUS, d);
    cmp("cont_status", {15'h0000, 1'b1, 16'h0004}, d);
    repeat (20) @(posedge ref_clk);
    cmp("cont_steps", {16'h0, t0 + 16'h0005}, {16'h0, taken});
    rd(OFS_COUNT, d);
    cmp("count_kept", 32'h0, d);
  endtask

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    slow = 1'b0;
    area_unit_on = 1'b0;
    line_unit_on = 1'b0;
    haze_unit_on = 1'b0;
    tex_unit_on = 1'b0;
    mask_unit_on = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    test_regs();
    test_line();
    test_gates();
    test_continue();
    close_out();
  end
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire

/* tb/rles_pipe_model.sv */
// Pipeline sink model: accepts edge steps promptly or with stalls
`timescale 1ns/100ps
`default_nettype none
module rles_pipe_model (
  input wire logic ref_clk, // Core clock
  input wire logic rst_n, // Async reset, active low
  input wire logic slow, // Stall every other cycle
  input wire logic frag_valid, // Step offered
  output logic frag_ready, // Step taken this cycle
  output logic [15:0] taken // Steps accepted so far
);
  // Toggling ready forces the block to hold its step data across stalls
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) frag_ready <= 1'b0;
    else frag_ready <= slow ? ~frag_ready : 1'b1;
  end
  // Count every step the pipeline accepts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) taken <= 16'h0000;
    else if (frag_valid && frag_ready) taken <= taken + 16'h0001;
  end
endmodule
`default_nettype wire
